/* rtl/maxop_core.sv */
// execute logic for literal/file add and and, bit set/clear, bit test-and-skip
// assumes an axi4-lite master on aclk; one write and one read in flight
//
// Overview of operation
// - add literal into accumulator, update c dc z
// - add accumulator and file register, update flags
// - destination bit zero selects accumulator, one file
// - file address from top two, low seven
// - and literal into accumulator, only zero flag
// - and accumulator with file, only zero flag
// - bit clear in file, flags untouched
// - bit set in file, flags untouched
// - bit position from opcode bits nine..seven
// - skip next instruction when tested bit clear
// - skip next instruction when tested bit set
// - skipped instruction replaced by no-operation cycle
// - digit carry is low nibble carry out
`timescale 1ns/1ns
`default_nettype none
`include "maxop_regs.svh"

module maxop_core (
    input wire logic aclk, // 10 mhz core clock
    input wire logic aresetn, // synchronous reset, low
    input wire logic [7:0] awaddr, // write address
    input wire logic [2:0] awprot, // unused protection
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic [2:0] arprot, // unused protection
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output maxop_pkg::maxop_flags_t flags, // live status flags
    output logic [7:0] acc, // working register
    output logic skip_pending // next instruction is discarded
);
    import maxop_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // {carry, digit carry, sum}; add only, no borrow path is needed here
    function automatic logic [9:0] add_fn(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        full = {1'b0, a} + {1'b0, b};
        return {full[8], lo[4], full[7:0]};
    endfunction

    function automatic logic [8:0] file_addr(input logic [15:0] op);
        return {op[15:14], op[6:0]};
    endfunction

    function automatic logic [7:0] bit_mask(input logic [15:0] op);
        return 8'h01 << op[9:7];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // registers, file port and the write decode shared by both processes
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic unsup_q, unsup_d, file_we, do_write;
    logic [7:0] awaddr_q, awaddr_d, acc_q, acc_d, file_wd, wr_addr;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wr_data;
    logic [3:0] wstrb_q, wstrb_d, wr_strb;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [15:0] instr_q, instr_d, cycles_q, cycles_d;
    logic [8:0] faddr_q, faddr_d, file_wa;
    maxop_flags_t flags_q, flags_d;
    maxop_state_t state_q, state_d;
    logic [7:0] file_mem [0:`MAXOP_FILE_DEPTH-1];

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------

    // address and data may come in either order; each is held until both
    assign awready = !aw_hold_q && !bvalid_q;
    assign wready = !w_hold_q && !bvalid_q;
    assign wr_addr = aw_hold_q ? awaddr_q : awaddr;
    assign wr_data = w_hold_q ? wdata_q : wdata;
    assign wr_strb = w_hold_q ? wstrb_q : wstrb;
    assign do_write = (aw_hold_q || (awvalid && awready)) && (w_hold_q || (wvalid && wready));

    always_comb
    begin
        aw_hold_d = aw_hold_q;
        awaddr_d = awaddr_q;
        w_hold_d = w_hold_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (awvalid && awready)
        begin
            aw_hold_d = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && wready)
        begin
            w_hold_d = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
        end
        if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            case (wr_addr)
                `MAXOP_OFS_INSTR, `MAXOP_OFS_ACC, `MAXOP_OFS_STATUS, `MAXOP_OFS_FADDR,
                `MAXOP_OFS_FDATA, `MAXOP_OFS_EXEC, `MAXOP_OFS_CYCLES:
                    bresp_d = `MAXOP_RESP_OKAY;
                default:
                    bresp_d = `MAXOP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q <= `MAXOP_RST_BYTE;
            w_hold_q <= 1'b0;
            wdata_q <= {2{`MAXOP_RST_WORD}};
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `MAXOP_RESP_OKAY;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            awaddr_q <= awaddr_d;
            w_hold_q <= w_hold_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ----------------------------------------------------------------
    // execute and software register writes
    // ----------------------------------------------------------------

    // one instruction per accepted write to the instruction register with byte strobes 0 and 1 both set
    always_comb
    begin
        logic [9:0] sum;
        logic [7:0] fval;
        logic [7:0] res;
        logic [8:0] fa;
        logic [7:0] mask;
        logic issue;
        sum = 10'h000;
        res = 8'h00;
        fa = file_addr(wr_data[15:0]);
        mask = bit_mask(wr_data[15:0]);
        fval = file_mem[fa];
        issue = do_write && (wr_addr == `MAXOP_OFS_INSTR) && (&wr_strb[1:0]);
        instr_d = instr_q;
        acc_d = acc_q;
        flags_d = flags_q;
        faddr_d = faddr_q;
        unsup_d = unsup_q;
        cycles_d = cycles_q;
        state_d = state_q;
        file_we = 1'b0;
        file_wa = fa;
        file_wd = fval;
        if (do_write && wr_strb[0])
        begin
            case (wr_addr)
                `MAXOP_OFS_ACC: acc_d = wr_data[7:0];
                `MAXOP_OFS_STATUS:
                begin
                    flags_d.c = wr_data[`MAXOP_ST_C];
                    flags_d.dc = wr_data[`MAXOP_ST_DC];
                    flags_d.z = wr_data[`MAXOP_ST_Z];
                end
                `MAXOP_OFS_FDATA:
                begin
                    file_we = 1'b1;
                    file_wa = faddr_q;
                    file_wd = wr_data[7:0];
                end
                `MAXOP_OFS_EXEC: unsup_d = 1'b0;
                default: ;
            endcase
        end
        if (do_write && (wr_addr == `MAXOP_OFS_FADDR) && (|wr_strb[1:0]))
            faddr_d = wr_data[8:0];
        if (issue)
        begin
            instr_d = wr_data[15:0];
            cycles_d = cycles_q + 16'h0001;
            case (state_q)
                MAXOP_SKIP:
                    state_d = MAXOP_RUN;
                MAXOP_RUN:
                begin
                    if (wr_data[15:8] == `MAXOP_OP_ADD_LIT)
                    begin
                        sum = add_fn(acc_q, wr_data[7:0]);
                        acc_d = sum[7:0];
                        flags_d.c = sum[9];
                        flags_d.dc = sum[8];
                        flags_d.z = (sum[7:0] == 8'h00);
                    end
                    else if (wr_data[15:8] == `MAXOP_OP_AND_LIT)
                    begin
                        res = acc_q & wr_data[7:0];
                        acc_d = res;
                        flags_d.z = (res == 8'h00);
                    end
                    else if (wr_data[13:8] == `MAXOP_OP_ADD_FILE
                             || wr_data[13:8] == `MAXOP_OP_AND_FILE)
                    begin
                        sum = add_fn(acc_q, fval);
                        if (wr_data[13:8] == `MAXOP_OP_ADD_FILE)
                        begin
                            res = sum[7:0];
                            flags_d.c = sum[9];
                            flags_d.dc = sum[8];
                        end
                        else
                            res = acc_q & fval;
                        flags_d.z = (res == 8'h00);
                        if (wr_data[7])
                        begin
                            file_we = 1'b1;
                            file_wd = res;
                        end
                        else
                            acc_d = res;
                    end
                    else if (wr_data[13:10] == `MAXOP_OP_BIT_CLR)
                    begin
                        file_we = 1'b1;
                        file_wd = fval & ~mask;
                    end
                    else if (wr_data[13:10] == `MAXOP_OP_BIT_SET)
                    begin
                        file_we = 1'b1;
                        file_wd = fval | mask;
                    end
                    else if (wr_data[13:10] == `MAXOP_OP_TST_CLR)
                    begin
                        if ((fval & mask) == 8'h00)
                            state_d = MAXOP_SKIP;
                    end
                    else if (wr_data[13:10] == `MAXOP_OP_TST_SET)
                    begin
                        if ((fval & mask) != 8'h00)
                            state_d = MAXOP_SKIP;
                    end
                    else
                        unsup_d = 1'b1; // set wins: exec-clear is a different write
                end
                default:
                    state_d = MAXOP_RUN;
            endcase
        end
    end

    // execute registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_q <= `MAXOP_RST_WORD;
            acc_q <= `MAXOP_RST_BYTE;
            flags_q <= 3'b000;
            faddr_q <= `MAXOP_RST_FADDR;
            unsup_q <= 1'b0;
            cycles_q <= `MAXOP_RST_WORD;
            state_q <= MAXOP_RUN;
        end
        else
        begin
            instr_q <= instr_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            faddr_q <= faddr_d;
            unsup_q <= unsup_d;
            cycles_q <= cycles_d;
            state_q <= state_d;
        end
    end

    // file memory has no reset; software must initialise what it uses
    always_ff @(posedge aclk)
    begin
        if (file_we)
            file_mem[file_wa] <= file_wd;
    end

    assign flags = flags_q;
    assign acc = acc_q;
    assign skip_pending = (state_q == MAXOP_SKIP);

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------

    // one read in flight; data is captured when the address is taken
    assign arready = !rvalid_q;

    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready)
            rvalid_d = 1'b0;
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = `MAXOP_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case (araddr)
                `MAXOP_OFS_INSTR: rdata_d[15:0] = instr_q;
                `MAXOP_OFS_ACC: rdata_d[7:0] = acc_q;
                `MAXOP_OFS_STATUS:
                begin
                    rdata_d[`MAXOP_ST_C] = flags_q.c;
                    rdata_d[`MAXOP_ST_DC] = flags_q.dc;
                    rdata_d[`MAXOP_ST_Z] = flags_q.z;
                end
                `MAXOP_OFS_FADDR: rdata_d[8:0] = faddr_q;
                `MAXOP_OFS_FDATA: rdata_d[7:0] = file_mem[faddr_q];
                `MAXOP_OFS_EXEC:
                begin
                    rdata_d[`MAXOP_EX_SKIP] = (state_q == MAXOP_SKIP);
                    rdata_d[`MAXOP_EX_UNSUP] = unsup_q;
                end
                `MAXOP_OFS_CYCLES: rdata_d[15:0] = cycles_q;
                default: rresp_d = `MAXOP_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= {2{`MAXOP_RST_WORD}};
            rresp_q <= `MAXOP_RESP_OKAY;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule

`default_nettype wire

/* rtl/maxop_regs.svh */
// constants for the add, and and bit-operation execute block
// assumes a byte-addressed axi4-lite slave with 32-bit data
`ifndef MAXOP_REGS_SVH
`define MAXOP_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MAXOP_OFS_INSTR 8'h00
`define MAXOP_OFS_ACC 8'h04
`define MAXOP_OFS_STATUS 8'h08
`define MAXOP_OFS_FADDR 8'h0c
`define MAXOP_OFS_FDATA 8'h10
`define MAXOP_OFS_EXEC 8'h14
`define MAXOP_OFS_CYCLES 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MAXOP_ST_C 0
`define MAXOP_ST_DC 1
`define MAXOP_ST_Z 2
`define MAXOP_EX_SKIP 0
`define MAXOP_EX_UNSUP 1

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define MAXOP_OP_ADD_LIT 8'h1c
`define MAXOP_OP_AND_LIT 8'h1b
`define MAXOP_OP_ADD_FILE 6'h07
`define MAXOP_OP_AND_FILE 6'h05
`define MAXOP_OP_BIT_CLR 4'hc
`define MAXOP_OP_BIT_SET 4'hd
`define MAXOP_OP_TST_CLR 4'he
`define MAXOP_OP_TST_SET 4'hf

// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define MAXOP_RST_BYTE 8'h00
`define MAXOP_RST_WORD 16'h0000
`define MAXOP_RST_FADDR 9'h000
`define MAXOP_RESP_OKAY 2'b00
`define MAXOP_RESP_SLVERR 2'b10
`define MAXOP_FILE_DEPTH 512

`endif

/* rtl/maxop_pkg.sv */
// types for the add, and and bit-operation execute block
// assumes maxop_regs.svh is not needed here; only types live in it
package maxop_pkg;

    // status flags handed to the rest of the core
    typedef struct packed {
        logic z;
        logic dc;
        logic c;
    } maxop_flags_t;

    // skip sequencing, one-hot
    typedef enum logic [1:0] {
        MAXOP_RUN = 2'b01,
        MAXOP_SKIP = 2'b10
    } maxop_state_t;

endpackage

/* testbench/maxop_core_assertions.sv */
// checker for the execute block: bus answers and instruction effects
// assumes it is bound to maxop_core and sees only the ports of that module
`timescale 1ns/1ns
`default_nettype none
module maxop_core_checker (
    input wire logic aclk, // core clock
    input wire logic aresetn, // sync reset, low
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // strobes
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp, // read response
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire maxop_pkg::maxop_flags_t flags, // status flags
    input wire logic [7:0] acc, // working register
    input wire logic skip_pending // discard pending
);
    import maxop_pkg::*;
    // ----------------------------------------------------------------
    // helper terms
    // ----------------------------------------------------------------
    // an opcode is counted here only when both write channels land together
    logic instr_wr;
    logic [8:0] lit_sum;
    logic [4:0] lit_nib;
    logic [7:0] lit_and;
    assign instr_wr = awvalid && awready && wvalid && wready && awaddr == 8'h00;
    assign lit_sum = {1'b0, acc} + {1'b0, wdata[7:0]};
    assign lit_nib = {1'b0, acc[3:0]} + {1'b0, wdata[3:0]};
    assign lit_and = acc & wdata[7:0];
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_add_literal: assert property (instr_wr && !skip_pending && wdata[15:8] == 8'h1c
        |=> {flags.c, acc} == $past(lit_sum) && flags.dc == $past(lit_nib[4])
        && flags.z == (acc == 8'h00)) else $error("add literal result wrong");
    a_and_literal: assert property (instr_wr && !skip_pending && wdata[15:8] == 8'h1b
        |=> acc == $past(lit_and) && $stable({flags.dc, flags.c}) && flags.z == (acc == 8'h00))
        else $error("and literal result wrong");
    a_bit_flags: assert property (instr_wr && wdata[13:12] == 2'b11
        |=> $stable(flags) && $stable(acc)) else $error("bit op touched flags");
    a_skip_discard: assert property (instr_wr && skip_pending
        |=> !skip_pending && $stable(acc) && $stable(flags)) else $error("skip not discarded");
    a_skip_only_test: assert property (instr_wr && !skip_pending && wdata[13:11] != 3'b111
        |=> !skip_pending) else $error("skip raised by non-test");
    a_write_answer: assert property (awvalid && awready && wvalid && wready
        |=> bvalid && !awready && !wready) else $error("write answer late");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_unmapped_read: assert property (arvalid && arready && araddr > 8'h18
        |=> rresp == 2'b10 && rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind maxop_core maxop_core_checker u_chk (.*);
`default_nettype wire

/* testbench/maxop_host.sv */
// axi4-lite master standing in for the fetch path and software
// assumes aclk is the core clock; slow delays bready and rready
`timescale 1ns/1ns
`default_nettype none
module maxop_host (
    input wire logic aclk, // core clock
    output logic [7:0] awaddr, // write address
    output logic awvalid, // aw valid
    input wire logic awready, // aw ready
    output logic [31:0] wdata, // write data
    output logic [3:0] wstrb, // strobes
    output logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // b valid
    output logic bready, // b ready
    output logic [7:0] araddr, // read address
    output logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp, // read response
    input wire logic rvalid, // r valid
    output logic rready // r ready
);
    logic slow = 1'b0;
    // idle bus from time zero
    initial
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    // every handshake is judged at the rising edge, before the slave updates
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 2'b11, !slow};
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do
        begin
            @(posedge aclk);
            if (bvalid && !bready)
                bready <= 1'b1;
        end
        while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 1'b1, !slow};
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        do
        begin
            @(posedge aclk);
            if (rvalid && !rready)
                rready <= 1'b1;
        end
        while (!(rvalid && rready));
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/tb_mcu_add_and_bit_op_execute.sv */
// self-checking bench for the add, and and bit-operation execute block
// assumes maxop_core with its checker bound and maxop_host as bus master
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_mcu_add_and_bit_op_execute;
    import maxop_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [2:0] awprot = 3'b000;
    logic [2:0] arprot = 3'b000;
    wire logic [7:0] awaddr, araddr, acc;
    wire logic [31:0] wdata, rdata;
    wire logic [3:0] wstrb;
    wire logic [1:0] bresp, rresp;
    wire logic awvalid, awready, wvalid, wready, bvalid, bready;
    wire logic arvalid, arready, rvalid, rready, skip_pending;
    maxop_flags_t flags;
    int fail_count = 0;
    int tests_run = 0;
    always #50 aclk = !aclk;
    maxop_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .flags(flags), .acc(acc), .skip_pending(skip_pending));
    maxop_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        `CHK("bresp", 2'b00, r)
    endtask
    task automatic chkreg(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        `CHK(n, e, d)
    endtask
    // opcodes: file form and bit form, address split as {top two, low seven}
    function automatic logic [31:0] fop(input logic [5:0] o, input logic d, input logic [8:0] f);
        return {16'h0, f[8:7], o, d, f[6:0]};
    endfunction
    function automatic logic [31:0] bop(input logic [1:0] k, input logic [2:0] b);
        return {16'h0, 2'b11, 2'b11, k, b, 7'h42};
    endfunction
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_add_lit();
        // {start, literal, sum, flags as z dc c}
        logic [31:0] tab [4] = '{32'h10152500, 32'hf8080007, 32'h0f011002, 32'hf0100005};
        for (int i = 0; i < 4; i++)
        begin
            wreg(8'h04, {24'h0, tab[i][31:24]});
            wreg(8'h00, {16'h1c, tab[i][23:16]});
            `CHK("acc", tab[i][15:8], acc)
            chkreg("acc_rd", 8'h04, {24'h0, tab[i][15:8]});
            `CHK("flags", tab[i][2:0], flags)
        end
    endtask
    task automatic t_add_file();
        wreg(8'h0c, 32'h042);
        wreg(8'h10, 32'h00);
        wreg(8'h0c, 32'h1c2);
        wreg(8'h10, 32'hc2);
        wreg(8'h04, 32'h17);
        wreg(8'h00, fop(6'h07, 1'b0, 9'h1c2));
        `CHK("acc", 8'hd9, acc)
        chkreg("file", 8'h10, 32'hc2);
        wreg(8'h00, fop(6'h07, 1'b1, 9'h1c2));
        `CHK("acc", 8'hd9, acc)
        `CHK("flags", 3'b001, flags)
        chkreg("file", 8'h10, 32'h9b);
        wreg(8'h0c, 32'h042);
        chkreg("alias", 8'h10, 32'h00);
        wreg(8'h0c, 32'h1c2);
    endtask
    task automatic t_and();
        wreg(8'h08, 32'h3);
        wreg(8'h04, 32'ha3);
        wreg(8'h00, 32'h1b5f);
        `CHK("acc", 8'h03, acc)
        `CHK("flags", 3'b011, flags)
        wreg(8'h00, 32'h1b00);
        `CHK("flags", 3'b111, flags)
        wreg(8'h10, 32'hc2);
        wreg(8'h04, 32'h17);
        wreg(8'h00, fop(6'h05, 1'b1, 9'h1c2));
        chkreg("file", 8'h10, 32'h02);
        `CHK("flags", 3'b011, flags)
        wreg(8'h00, fop(6'h05, 1'b0, 9'h1c2));
        `CHK("acc", 8'h02, acc)
    endtask
    task automatic t_bits();
        wreg(8'h08, 32'h5);
        for (int b = 0; b < 8; b++)
        begin
            wreg(8'h10, 32'h00);
            wreg(8'h00, bop(2'b01, b[2:0]));
            chkreg("set", 8'h10, 32'h1 << b);
            wreg(8'h10, 32'hff);
            wreg(8'h00, bop(2'b00, b[2:0]));
            chkreg("clr", 8'h10, 32'hff ^ (32'h1 << b));
            `CHK("flags", 3'b101, flags)
        end
    endtask
    // each test is followed by an add of one; a taken skip must swallow it
    task automatic t_skip();
        logic [7:0] fv = 8'ha5;
        logic [31:0] c0;
        logic [1:0] r;
        logic sk;
        wreg(8'h10, {24'h0, fv});
        for (int i = 0; i < 16; i++)
        begin
            sk = i[3] ? fv[i[2:0]] : !fv[i[2:0]];
            wreg(8'h04, 32'h40);
            wreg(8'h08, 32'h5);
            host.rd(8'h18, c0, r);
            wreg(8'h00, bop({1'b1, i[3]}, i[2:0]));
            `CHK("skip", sk, skip_pending)
            `CHK("flags", 3'b101, flags)
            wreg(8'h00, 32'h1c01);
            `CHK("next", sk ? 8'h40 : 8'h41, acc)
            `CHK("skip", 1'b0, skip_pending)
            chkreg("cycles", 8'h18, c0 + 32'h2);
        end
    endtask
    // refused places, answered through a slow master
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        host.slow = 1'b1;
        host.rd(8'h1c, d, r);
        `CHK("rresp", 2'b10, r)
        `CHK("rdata", 32'h0, d)
        host.wr(8'h20, 32'hff, r);
        `CHK("bresp", 2'b10, r)
        host.slow = 1'b0;
    endtask
    // ----------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        final_report();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("acc_rst", 8'h00, acc)
        `CHK("flags_rst", 3'b000, flags)
        t_add_lit();
        t_add_file();
        t_and();
        t_bits();
        t_skip();
        t_unmapped();
        final_report();
    end
endmodule
`default_nettype wire
